// [rtl/srm_relay.sv]
// srm_relay: two status relay contacts with avalon-mm configuration
// assumes controller status pins are asynchronous to CLK
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module srm_relay #(
  parameter int NUM_CTRL = srm_pkg::NUM_CTRL,
  parameter int NUM_INPUT = srm_pkg::NUM_INPUT
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // avalon-mm slave
  input wire logic [srm_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [srm_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [srm_pkg::DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // controller status, one bit per controller
  input wire logic [NUM_CTRL-1:0] CTRL_RUNNING,
  input wire logic [NUM_CTRL-1:0] CTRL_HIGH_TEMP,
  input wire logic [NUM_CTRL-1:0] CTRL_ALERT,
  input wire logic [NUM_CTRL-1:0] CTRL_PROC,
  // directly connected controller
  input wire logic CONN_PROC,
  input wire logic CONN_PURGE,
  // contact outputs, high means energised contact state
  output logic NC_OPEN,
  output logic NO_CLOSED
);

  localparam int SYNC_W = 4 * NUM_CTRL + 2;
  localparam int VW = srm_pkg::VAL_W;

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [3:0] nc_mode;
    logic [srm_pkg::SEL_W-1:0] nc_sel;
    logic [VW-1:0] nc_setpoint;
    logic [VW-1:0] nc_deadband;
    logic [3:0] no_mode;
    logic [srm_pkg::SEL_W-1:0] no_sel;
    logic [VW-1:0] no_setpoint;
    logic [VW-1:0] no_deadband;
    logic [NUM_INPUT-1:0][VW-1:0] value;
    logic [srm_pkg::DATA_W-1:0] rdata;
    logic ack;
  } srm_relay_s;

  srm_relay_s state;
  srm_relay_s next_state;

  logic nc_active;
  logic no_active;
  logic nc_trip;
  logic no_trip;
  logic any_running;
  logic any_high_temp;
  logic any_alert;
  logic any_proc;
  logic conn_proc;
  logic conn_purge;

  function automatic logic [VW-1:0] merge16(
    input logic [VW-1:0] old,
    input logic [srm_pkg::DATA_W-1:0] wd,
    input logic [3:0] be
  );
    logic [VW-1:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction : merge16

  function automatic logic [srm_pkg::DATA_W-1:0] ext(
    input logic [VW-1:0] v
  );
    return {{(srm_pkg::DATA_W-VW){1'b0}}, v};
  endfunction : ext

  ////////////////////////////////////////////////////////////////////////
  // synchronised conditions, read only from the second stage

  assign any_running = |state.sync2[0 +: NUM_CTRL];
  assign any_high_temp = |state.sync2[NUM_CTRL +: NUM_CTRL];
  assign any_alert = |state.sync2[2*NUM_CTRL +: NUM_CTRL];
  assign any_proc = |state.sync2[3*NUM_CTRL +: NUM_CTRL];
  assign conn_proc = state.sync2[4*NUM_CTRL];
  assign conn_purge = state.sync2[4*NUM_CTRL+1];

  ////////////////////////////////////////////////////////////////////////
  // register access and next state

  always_comb begin
    logic [srm_pkg::ADDR_W-1:0] a;
    logic [srm_pkg::DATA_W-1:0] wd;
    logic hit_value;
    logic [srm_pkg::SEL_W-1:0] vidx;
    a = AVS_ADDRESS;
    wd = AVS_WRITEDATA;
    hit_value = (a >= srm_pkg::OFF_VALUE_BASE) &&
      (a < srm_pkg::OFF_VALUE_BASE + 6'(4 * NUM_INPUT));
    vidx = srm_pkg::SEL_W'((a - srm_pkg::OFF_VALUE_BASE) >> 2);
    next_state = state;
    next_state.sync1 = {CONN_PURGE, CONN_PROC, CTRL_PROC, CTRL_ALERT,
      CTRL_HIGH_TEMP, CTRL_RUNNING};
    next_state.sync2 = state.sync1;
    // one wait state: every access answers on its second edge
    next_state.ack = (AVS_READ | AVS_WRITE) & ~state.ack;
    // a write lands only on the edge that completes it
    if (AVS_WRITE && state.ack) begin
      case (a)
        srm_pkg::OFF_NC_MODE: begin
          if (AVS_BYTEENABLE[0]) begin
            next_state.nc_mode = wd[srm_pkg::MODE_LSB +: 4];
            next_state.nc_sel = wd[srm_pkg::SEL_LSB +: srm_pkg::SEL_W];
          end
        end
        srm_pkg::OFF_NC_SETPOINT: begin
          next_state.nc_setpoint = merge16(state.nc_setpoint, wd,
            AVS_BYTEENABLE);
        end
        srm_pkg::OFF_NC_DEADBAND: begin
          next_state.nc_deadband = merge16(state.nc_deadband, wd,
            AVS_BYTEENABLE);
        end
        srm_pkg::OFF_NO_MODE: begin
          if (AVS_BYTEENABLE[0]) begin
            next_state.no_mode = wd[srm_pkg::MODE_LSB +: 4];
            next_state.no_sel = wd[srm_pkg::SEL_LSB +: srm_pkg::SEL_W];
          end
        end
        srm_pkg::OFF_NO_SETPOINT: begin
          next_state.no_setpoint = merge16(state.no_setpoint, wd,
            AVS_BYTEENABLE);
        end
        srm_pkg::OFF_NO_DEADBAND: begin
          next_state.no_deadband = merge16(state.no_deadband, wd,
            AVS_BYTEENABLE);
        end
        default: begin
          // measured values arrive from the controller network by software
          if (hit_value) begin
            next_state.value[vidx] = merge16(state.value[vidx], wd,
              AVS_BYTEENABLE);
          end
        end
      endcase
    end
    if (AVS_READ && !state.ack) begin
      case (a)
        srm_pkg::OFF_NC_MODE: begin
          next_state.rdata = ext({{(VW-6){1'b0}}, state.nc_sel,
            state.nc_mode});
        end
        srm_pkg::OFF_NC_SETPOINT: begin
          next_state.rdata = ext(state.nc_setpoint);
        end
        srm_pkg::OFF_NC_DEADBAND: begin
          next_state.rdata = ext(state.nc_deadband);
        end
        srm_pkg::OFF_NO_MODE: begin
          next_state.rdata = ext({{(VW-6){1'b0}}, state.no_sel,
            state.no_mode});
        end
        srm_pkg::OFF_NO_SETPOINT: begin
          next_state.rdata = ext(state.no_setpoint);
        end
        srm_pkg::OFF_NO_DEADBAND: begin
          next_state.rdata = ext(state.no_deadband);
        end
        srm_pkg::OFF_STATUS: begin
          next_state.rdata = srm_pkg::UNMAPPED_READ;
          next_state.rdata[srm_pkg::ST_NC_OPEN] = nc_active;
          next_state.rdata[srm_pkg::ST_NO_CLOSED] = no_active;
          next_state.rdata[srm_pkg::ST_NC_TRIP] = nc_trip;
          next_state.rdata[srm_pkg::ST_NO_TRIP] = no_trip;
        end
        default: begin
          if (hit_value) begin
            next_state.rdata = ext(state.value[vidx]);
          end else begin
            next_state.rdata = srm_pkg::UNMAPPED_READ;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state <= '0;
      state.nc_mode <= srm_pkg::RST_MODE;
      state.no_mode <= srm_pkg::RST_MODE;
      state.nc_setpoint <= srm_pkg::RST_VALUE;
      state.no_setpoint <= srm_pkg::RST_VALUE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // the two contacts, each with its own configuration

  srm_contact #(.VAL_W(VW)) u_nc (
    .clk(CLK),
    .rstn(RSTN),
    .mode(state.nc_mode),
    .setpoint(state.nc_setpoint),
    .deadband(state.nc_deadband),
    .any_running(any_running),
    .any_high_temp(any_high_temp),
    .any_alert(any_alert),
    .any_proc(any_proc),
    .conn_proc(conn_proc),
    .conn_purge(conn_purge),
    .temp_value(state.value[state.nc_sel]),
    .input_value(state.value[state.nc_sel]),
    .active(nc_active),
    .tripped(nc_trip)
  );

  srm_contact #(.VAL_W(VW)) u_no (
    .clk(CLK),
    .rstn(RSTN),
    .mode(state.no_mode),
    .setpoint(state.no_setpoint),
    .deadband(state.no_deadband),
    .any_running(any_running),
    .any_high_temp(any_high_temp),
    .any_alert(any_alert),
    .any_proc(any_proc),
    .conn_proc(conn_proc),
    .conn_purge(conn_purge),
    .temp_value(state.value[state.no_sel]),
    .input_value(state.value[state.no_sel]),
    .active(no_active),
    .tripped(no_trip)
  );

  // disabled rests: nc closed (not open), no open (not closed)
  assign NC_OPEN = nc_active;
  assign NO_CLOSED = no_active;
  assign AVS_READDATA = state.rdata;
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~state.ack;

endmodule : srm_relay
`default_nettype wire

// [inc/srm_pkg.sv]
// srm_pkg: register map, mode codes and widths for the status relay logic
// assumes a 32-bit avalon-mm slave with word addressing in bytes
package srm_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;
  localparam int VAL_W = 16;
  localparam int NUM_CTRL = 8;
  localparam int NUM_INPUT = 4;
  localparam int SEL_W = 2;

  // contact modes
  localparam logic [3:0] MODE_DISABLED = 4'h0;
  localparam logic [3:0] MODE_STARTED = 4'h1;
  localparam logic [3:0] MODE_HIGH_TEMP = 4'h2;
  localparam logic [3:0] MODE_NO_ALERT = 4'h3;
  localparam logic [3:0] MODE_APP_PROC = 4'h4;
  localparam logic [3:0] MODE_CTRL_PROC = 4'h5;
  localparam logic [3:0] MODE_TEMP_TRIP = 4'h6;
  localparam logic [3:0] MODE_INPUT_TRIP = 4'h7;
  localparam logic [3:0] MODE_PURGE = 4'h8;

  // byte offsets
  localparam logic [ADDR_W-1:0] OFF_NC_MODE = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_NC_SETPOINT = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_NC_DEADBAND = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_NO_MODE = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_NO_SETPOINT = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_NO_DEADBAND = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_VALUE_BASE = 6'h20;

  // mode register fields: [3:0] mode, [5:4] input select
  localparam int MODE_LSB = 0;
  localparam int SEL_LSB = 4;

  // status register fields
  localparam int ST_NC_OPEN = 0;
  localparam int ST_NO_CLOSED = 1;
  localparam int ST_NC_TRIP = 2;
  localparam int ST_NO_TRIP = 3;

  localparam logic [3:0] RST_MODE = 4'h0;
  localparam logic [VAL_W-1:0] RST_VALUE = 16'h0000;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

endpackage : srm_pkg

// [rtl/srm_contact.sv]
// srm_contact: decision logic for one status contact
// assumes condition inputs are already synchronised to CLK
`timescale 1ns/10ps
`default_nettype none
module srm_contact #(
  parameter int VAL_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // configuration
  input wire logic [3:0] mode,
  input wire logic [VAL_W-1:0] setpoint,
  input wire logic [VAL_W-1:0] deadband,
  // conditions
  input wire logic any_running,
  input wire logic any_high_temp,
  input wire logic any_alert,
  input wire logic any_proc,
  input wire logic conn_proc,
  input wire logic conn_purge,
  input wire logic [VAL_W-1:0] temp_value,
  input wire logic [VAL_W-1:0] input_value,
  // result
  output logic active,
  output logic tripped
);

  typedef struct packed {
    logic active;
    logic tripped;
  } srm_contact_s;

  srm_contact_s state;
  srm_contact_s next_state;

  function automatic logic trip_eval(
    input logic was,
    input logic [VAL_W-1:0] value,
    input logic [VAL_W-1:0] sp,
    input logic [VAL_W-1:0] db
  );
    logic [VAL_W:0] low;
    logic res;
    // saturate so a deadband above the setpoint never wraps
    low = {1'b0, sp} - {1'b0, db};
    if (low[VAL_W]) begin
      low = '0;
    end
    if (value > sp) begin
      res = 1'b1;
    end else if ({1'b0, value} < low) begin
      res = 1'b0;
    end else begin
      res = was;
    end
    return res;
  endfunction : trip_eval

  always_comb begin
    next_state = state;
    // re-evaluated every cycle from the live conditions
    case (mode)
      srm_pkg::MODE_DISABLED: begin
        next_state.active = 1'b0;
        next_state.tripped = 1'b0;
      end
      srm_pkg::MODE_STARTED: begin
        next_state.active = any_running;
      end
      srm_pkg::MODE_HIGH_TEMP: begin
        next_state.active = any_high_temp;
      end
      srm_pkg::MODE_NO_ALERT: begin
        next_state.active = ~any_alert;
      end
      srm_pkg::MODE_APP_PROC: begin
        next_state.active = any_proc;
      end
      srm_pkg::MODE_CTRL_PROC: begin
        next_state.active = conn_proc;
      end
      srm_pkg::MODE_TEMP_TRIP: begin
        next_state.tripped = trip_eval(state.tripped, temp_value,
          setpoint, deadband);
        next_state.active = next_state.tripped;
      end
      srm_pkg::MODE_INPUT_TRIP: begin
        next_state.tripped = trip_eval(state.tripped, input_value,
          setpoint, deadband);
        next_state.active = next_state.tripped;
      end
      srm_pkg::MODE_PURGE: begin
        next_state.active = conn_purge;
      end
      default: begin
        // unknown codes rest like disabled, the safe state
        next_state.active = 1'b0;
        next_state.tripped = 1'b0;
      end
    endcase
    if (mode != srm_pkg::MODE_TEMP_TRIP &&
        mode != srm_pkg::MODE_INPUT_TRIP) begin
      next_state.tripped = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign active = state.active;
  assign tripped = state.tripped;

endmodule : srm_contact
`default_nettype wire

// [bench/srm_relay_asserts.sv]
// srm_relay_asserts: port-level checks of the two status contacts
// assumes binding to srm_relay; modes are mirrored from avalon writes
`timescale 1ns/10ps
`default_nettype none
module srm_relay_asserts #(
  parameter int NUM_CTRL = srm_pkg::NUM_CTRL,
  parameter int NUM_INPUT = srm_pkg::NUM_INPUT
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // avalon-mm slave
  input wire logic [srm_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_WRITE,
  input wire logic [srm_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic AVS_WAITREQUEST,
  // controller status
  input wire logic [NUM_CTRL-1:0] CTRL_RUNNING,
  input wire logic [NUM_CTRL-1:0] CTRL_HIGH_TEMP,
  input wire logic [NUM_CTRL-1:0] CTRL_ALERT,
  input wire logic [NUM_CTRL-1:0] CTRL_PROC,
  input wire logic CONN_PROC,
  input wire logic CONN_PURGE,
  // contacts
  input wire logic NC_OPEN,
  input wire logic NO_CLOSED
);
  logic [3:0] nc_mode;
  logic [3:0] no_mode;
  logic wr_ok;
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  // mirror only; a mode write is what the contact logic follows
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      nc_mode <= srm_pkg::MODE_DISABLED;
      no_mode <= srm_pkg::MODE_DISABLED;
    end else if (wr_ok && AVS_ADDRESS == srm_pkg::OFF_NC_MODE) begin
      nc_mode <= AVS_WRITEDATA[3:0];
    end else if (wr_ok && AVS_ADDRESS == srm_pkg::OFF_NO_MODE) begin
      no_mode <= AVS_WRITEDATA[3:0];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////
  property p_nc_off;
    (nc_mode == srm_pkg::MODE_DISABLED)[*2] |-> !NC_OPEN;
  endproperty
  a_nc_off: assert property (p_nc_off) else $error("nc not closed");
  property p_no_off;
    (no_mode == srm_pkg::MODE_DISABLED)[*2] |-> !NO_CLOSED;
  endproperty
  a_no_off: assert property (p_no_off) else $error("no not open");
  property p_run;
    (nc_mode == srm_pkg::MODE_STARTED)[*4] |->
      NC_OPEN == $past(|CTRL_RUNNING, 3);
  endproperty
  a_run: assert property (p_run) else $error("started wrong");
  property p_hot;
    (no_mode == srm_pkg::MODE_HIGH_TEMP && |CTRL_HIGH_TEMP)[*4] |-> NO_CLOSED;
  endproperty
  a_hot: assert property (p_hot) else $error("high temp wrong");
  property p_alert;
    (nc_mode == srm_pkg::MODE_NO_ALERT)[*4] |->
      NC_OPEN == !$past(|CTRL_ALERT, 3);
  endproperty
  a_alert: assert property (p_alert) else $error("no alert wrong");
  property p_app;
    (no_mode == srm_pkg::MODE_APP_PROC && CTRL_PROC == '0)[*4] |-> !NO_CLOSED;
  endproperty
  a_app: assert property (p_app) else $error("app proc wrong");
  property p_conn;
    (nc_mode == srm_pkg::MODE_CTRL_PROC && CONN_PROC)[*4] |-> NC_OPEN;
  endproperty
  a_conn: assert property (p_conn) else $error("ctrl proc wrong");
  property p_purge;
    (no_mode == srm_pkg::MODE_PURGE)[*4] |->
      NO_CLOSED == $past(CONN_PURGE, 3);
  endproperty
  a_purge: assert property (p_purge) else $error("purge wrong");
  c_trip: cover property (nc_mode == srm_pkg::MODE_TEMP_TRIP && NC_OPEN);
  c_purge: cover property (no_mode == srm_pkg::MODE_PURGE && NO_CLOSED);
  c_both: cover property (NC_OPEN && NO_CLOSED);
endmodule : srm_relay_asserts
bind srm_relay srm_relay_asserts #(.NUM_CTRL(NUM_CTRL), .NUM_INPUT(NUM_INPUT))
  u_srm_relay_asserts (.CLK(CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .CTRL_RUNNING(CTRL_RUNNING), .CTRL_HIGH_TEMP(CTRL_HIGH_TEMP),
  .CTRL_ALERT(CTRL_ALERT), .CTRL_PROC(CTRL_PROC), .CONN_PROC(CONN_PROC),
  .CONN_PURGE(CONN_PURGE), .NC_OPEN(NC_OPEN), .NO_CLOSED(NO_CLOSED));
`default_nettype wire

// [bench/srm_ctrl_model.sv]
// srm_ctrl_model: burner controllers reporting status levels
// assumes report() is called just after a rising edge of clk
`timescale 1ns/10ps
`default_nettype none
module srm_ctrl_model (
  // clock
  input wire logic clk,
  // status levels towards the relay block
  output logic [7:0] running,
  output logic [7:0] high_temp,
  output logic [7:0] alert,
  output logic [7:0] proc,
  output logic conn_proc,
  output logic conn_purge
);
  initial begin
    running = 8'h00;
    high_temp = 8'h00;
    alert = 8'h00;
    proc = 8'h00;
    conn_proc = 1'b0;
    conn_purge = 1'b0;
  end
  // lag models a slow network update; levels change on a rising edge
  task automatic report(input logic [7:0] r, input logic [7:0] h,
    input logic [7:0] a, input logic [7:0] p, input logic cp,
    input logic cg, input int lag);
    repeat (lag) @(posedge clk);
    running <= r;
    high_temp <= h;
    alert <= a;
    proc <= p;
    conn_proc <= cp;
    conn_purge <= cg;
  endtask : report
endmodule : srm_ctrl_model
`default_nettype wire

// [bench/srm_relay_test.sv]
// srm_relay_test: directed bench for the status relay block
// assumes 20 MHz clock and the controller model on the status pins
`timescale 1ns/10ps
`default_nettype none
module srm_relay_test;
  logic CLK;
  logic RSTN;
  logic [5:0] AVS_ADDRESS;
  logic AVS_READ;
  logic AVS_WRITE;
  logic [31:0] AVS_WRITEDATA;
  logic [3:0] AVS_BYTEENABLE;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic [7:0] run, hot, alrt, prc;
  logic cp, cg, NC_OPEN, NO_CLOSED;
  int errors;
  int checks;
  srm_relay u_srm_relay (.CLK(CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CTRL_RUNNING(run), .CTRL_HIGH_TEMP(hot), .CTRL_ALERT(alrt),
    .CTRL_PROC(prc), .CONN_PROC(cp), .CONN_PURGE(cg),
    .NC_OPEN(NC_OPEN), .NO_CLOSED(NO_CLOSED));
  srm_ctrl_model u_srm_ctrl_model (.clk(CLK), .running(run),
    .high_temp(hot), .alert(alrt), .proc(prc), .conn_proc(cp),
    .conn_purge(cg));
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request stands until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a,
    input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    q = 32'h0;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do begin
      @(posedge CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    if (AVS_WAITREQUEST !== 1'b0) begin
      errors++;
      $display("[FAIL] %0t bus wait timed out", $time);
      tally_and_finish();
    end
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    // one idle edge so the next request never reuses this time step
    @(posedge CLK);
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(q, exp);
  endtask : rd
  task automatic look(input int n, input logic nc, input logic no);
    repeat (n) @(negedge CLK);
    chk({31'h0, NC_OPEN}, {31'h0, nc});
    chk({31'h0, NO_CLOSED}, {31'h0, no});
    @(posedge CLK);
  endtask : look
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    look(1, 1'b0, 1'b0);
    rd(srm_pkg::OFF_NC_MODE, 32'h0);
    rd(6'h3c, srm_pkg::UNMAPPED_READ);
  endtask : t_reset
  // off case for ctrl proc and purge keeps a neighbouring condition busy so only the chosen one acts
  task automatic t_mode(input logic [3:0] m);
    logic [7:0] b;
    logic [7:0] z;
    logic f;
    z = 8'h00;
    f = 1'b0;
    wr(srm_pkg::OFF_NC_MODE, {28'h0, m});
    wr(srm_pkg::OFF_NO_MODE, {28'h0, m});
    for (int on = 0; on < 2; on++) begin
      b = on ? 8'h80 : 8'h00;
      case (m)
        srm_pkg::MODE_STARTED:
          u_srm_ctrl_model.report(b, z, z, z, f, f, 1);
        srm_pkg::MODE_HIGH_TEMP:
          u_srm_ctrl_model.report(z, b, z, z, f, f, 2);
        srm_pkg::MODE_NO_ALERT:
          u_srm_ctrl_model.report(z, z, b ^ 8'h80, z, f, f, 1);
        srm_pkg::MODE_APP_PROC:
          u_srm_ctrl_model.report(z, z, z, b, f, f, 3);
        srm_pkg::MODE_CTRL_PROC:
          u_srm_ctrl_model.report(z, z, z, ~b, on[0], f, 1);
        default:
          u_srm_ctrl_model.report(z, z, z, z, !on[0], on[0], 2);
      endcase
      look(4, on[0], on[0]);
    end
    rd(srm_pkg::OFF_STATUS, 32'h3);
  endtask : t_mode
  task automatic t_disabled;
    logic [31:0] q;
    u_srm_ctrl_model.report(8'hff, 8'hff, 8'h00, 8'hff, 1'b1, 1'b1, 1);
    bus(1'b1, srm_pkg::OFF_NC_MODE, 32'h1, 4'h0, q);
    rd(srm_pkg::OFF_NC_MODE, 32'h8);
    wr(srm_pkg::OFF_NC_MODE, 32'h0);
    wr(srm_pkg::OFF_NO_MODE, 32'h9);
    look(4, 1'b0, 1'b0);
  endtask : t_disabled
  task automatic t_trip;
    wr(srm_pkg::OFF_NC_SETPOINT, 32'h64);
    wr(srm_pkg::OFF_NC_DEADBAND, 32'ha);
    wr(srm_pkg::OFF_NO_SETPOINT, 32'hc8);
    wr(srm_pkg::OFF_NO_DEADBAND, 32'h0);
    wr(srm_pkg::OFF_NC_MODE, 32'h16);
    wr(srm_pkg::OFF_NO_MODE, 32'h27);
    wr(6'h24, 32'h64);
    look(2, 1'b0, 1'b0);
    wr(6'h24, 32'h65);
    look(2, 1'b1, 1'b0);
    wr(6'h24, 32'h5a);
    look(2, 1'b1, 1'b0);
    wr(6'h28, 32'hc9);
    look(2, 1'b1, 1'b1);
    rd(srm_pkg::OFF_STATUS, 32'hf);
    wr(6'h24, 32'h59);
    look(2, 1'b0, 1'b1);
    wr(6'h28, 32'hc8);
    look(2, 1'b0, 1'b1);
    wr(6'h28, 32'hc7);
    look(2, 1'b0, 1'b0);
  endtask : t_trip
  ////////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    checks = 0;
    RSTN = 1'b0;
    AVS_ADDRESS = 6'h00;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0;
    AVS_BYTEENABLE = 4'hf;
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    t_reset();
    t_mode(srm_pkg::MODE_STARTED);
    t_mode(srm_pkg::MODE_HIGH_TEMP);
    t_mode(srm_pkg::MODE_NO_ALERT);
    t_mode(srm_pkg::MODE_APP_PROC);
    t_mode(srm_pkg::MODE_CTRL_PROC);
    t_mode(srm_pkg::MODE_PURGE);
    t_disabled();
    t_trip();
    tally_and_finish();
  end
endmodule : srm_relay_test
`default_nettype wire
